// >>> src/exc_pkg.sv
// Functional notes
// - Only the highest priority pending exception is accepted, fixed order.
// - External or power-on reset vectors to reset address, sets bootstrap and error level.
// - Soft reset vectors to reset address, sets bootstrap, soft reset, error level.
// - Non-maskable interrupt vectors to reset address; ranks below single step, debug interrupt.
// - Debug exceptions vector to debug address, set own debug bit, no code.
// - Debug interrupt comes from external input or the break request bit.
// - Complex breakpoint sets imprecise break bits; lowest priority, debug address.
// - Conflicting TLB write gives machine check at base plus 0x180, code 0x18.
// - Unmasked interrupt takes code 0x00, loads priority level, per-source vector.
// - Deferred watch vectors to general address, sets watch pending, code 0x17.
// - Watch match gives code 0x17; fetch watches rank above data watches.
// - Fetch/load address errors code 0x04; store address errors code 0x05.
// - Fetch/load TLB fault code 0x02; fetch vector is base when level clear.
// - Store TLB fault vectors to general address, code 0x03.
// - Fetch hitting execute-inhibit page gives code 0x14 at general address.
// - Fetch bus error code 0x06; data bus error code 0x07.
// - Coprocessor unusable 0x0b outranks reserved instruction 0x0a.
// - Instruction-based faults report codes 0x08 to 0x0c at general address.
// - True trap gives code 0x0d at general address.
// - Configuration bit is registered into the compressed instruction set flag every cycle.
package exc_pkg;

   // ****************************************
   // Vectors and codes
   // ****************************************
   localparam logic [31:0] RESET_VECTOR = 32'hbfc0_0000;
   localparam logic [31:0] DEBUG_VECTOR = 32'hbfc0_0480;
   localparam logic [31:0] GENERAL_OFS  = 32'h0000_0180;
   localparam logic [31:0] BASE_RESET   = 32'h8000_0000;
   localparam logic [4:0]  CODE_INT     = 5'h00;
   localparam logic [4:0]  CODE_TLB_LOAD_FETCH_FAULT    = 5'h02;
   localparam logic [4:0]  CODE_TLB_STORE_FAULT    = 5'h03;
   localparam logic [4:0]  CODE_LOAD_FETCH_ADDRESS_ERROR    = 5'h04;
   localparam logic [4:0]  CODE_STORE_ADDRESS_ERROR    = 5'h05;
   localparam logic [4:0]  CODE_IBE     = 5'h06;
   localparam logic [4:0]  CODE_DBE     = 5'h07;
   localparam logic [4:0]  CODE_RI      = 5'h0a;
   localparam logic [4:0]  CODE_CPU     = 5'h0b;
   localparam logic [4:0]  CODE_EXEC_LO = 5'h08;
   localparam logic [4:0]  CODE_EXEC_HI = 5'h0c;
   localparam logic [4:0]  CODE_TRAP    = 5'h0d;
   localparam logic [4:0]  CODE_XI      = 5'h14;
   localparam logic [4:0]  CODE_WATCH   = 5'h17;
   localparam logic [4:0]  CODE_MACHINE_CHECK_FLAG  = 5'h18;

   // ****************************************
   // Source indices, highest priority first
   // ****************************************
   localparam int NSRC        = 27;
   localparam int S_RESET     = 0;
   localparam int S_SOFT      = 1;
   localparam int S_DSS       = 2;
   localparam int S_DEBUG_INTERRUPT      = 3;
   localparam int S_NMI       = 4;
   localparam int S_MACHINE_CHECK_FLAG    = 5;
   localparam int S_INT       = 6;
   localparam int S_DWATCH    = 7;
   localparam int S_DIB       = 8;
   localparam int S_FWATCH    = 9;
   localparam int S_FADDR     = 10;
   localparam int S_FTLB      = 11;
   localparam int S_XI        = 12;
   localparam int S_IBE       = 13;
   localparam int S_CPU       = 14;
   localparam int S_RI        = 15;
   localparam int S_EXEC      = 16;
   localparam int S_TRAP      = 17;
   localparam int S_DDB       = 18;
   localparam int S_DWATCHD   = 19;
   localparam int S_LADDR     = 20;
   localparam int S_SADDR     = 21;
   localparam int S_LTLB      = 22;
   localparam int S_STLB      = 23;
   localparam int S_DBE       = 24;
   localparam int S_DEBUG_LOAD_BREAK_CMP  = 25;
   localparam int S_COMPLEX_BREAKPOINT      = 26;

   // Debug status bit positions
   localparam int DB_DSS  = 0;
   localparam int DB_DEBUG_INTERRUPT = 1;
   localparam int DB_DIB  = 2;
   localparam int DB_DEBUG_LOAD_BREAK = 3;
   localparam int DB_DEBUG_STORE_BREAK = 4;
   localparam int DB_IIMP = 5;
   localparam int DB_LIMP = 6;
   localparam int DB_SIMP = 7;

   typedef enum logic [1:0] {KIND_RESET, KIND_DEBUG, KIND_GENERAL, KIND_INT} kind_e;

endpackage : exc_pkg

// >>> src/exc_sel_if.sv
`timescale 1ns/1ns
// Carries the pending vector into the picker and the winner back
interface exc_sel_if;
   logic [26:0] pending;
   logic        any;
   logic [4:0]  index;
   modport picker (input pending, output any, output index);
   modport user   (output pending, input any, input index);
endinterface : exc_sel_if

// >>> src/exc_pick.sv
`timescale 1ns/1ns
// Fixed priority picker, lowest index wins
module exc_pick
(
   exc_sel_if.picker sel
);
   import exc_pkg::*;

   // ****************************************
   // Priority scan
   // ****************************************
   // Scan from lowest priority up so the highest pending is last written
   always_comb
   begin
      sel.any   = |sel.pending;
      sel.index = 5'h00;
      for (int k = NSRC - 1; k >= 0; k--)
      begin
         if (sel.pending[k])
         begin
            sel.index = 5'(k);
         end
      end
   end

endmodule : exc_pick

// >>> src/cpu_exception_prioritizer.sv
`timescale 1ns/1ns
module cpu_exception_prioritizer
(
   input  wire logic        clk_i,
   input  wire logic        rstn_i,
   input  wire logic        power_on_reset_i,
   input  wire logic        external_reset_pin_i,
   input  wire logic        soft_reset_req_i,
   input  wire logic        debug_single_step_i,
   input  wire logic        debug_interrupt_input_i,
   input  wire logic        break_request_bit_i,
   input  wire logic        nmi_i,
   input  wire logic        tlb_conflict_i,
   input  wire logic        int_req_i,
   input  wire logic [2:0]  int_level_i,
   input  wire logic [31:0] int_vector_i,
   input  wire logic        deferred_watch_i,
   input  wire logic        debug_instruction_break_i,
   input  wire logic        fetch_watch_i,
   input  wire logic        fetch_address_error_i,
   input  wire logic        tlb_fetch_fault_i,
   input  wire logic        execute_inhibit_bit_i,
   input  wire logic        instruction_bus_error_i,
   input  wire logic        cop_unusable_i,
   input  wire logic        reserved_instr_i,
   input  wire logic        exec_fault_i,
   input  wire logic [4:0]  exec_code_i,
   input  wire logic        trap_exception_i,
   input  wire logic        debug_load_break_i,
   input  wire logic        debug_store_break_i,
   input  wire logic        data_watch_i,
   input  wire logic        load_address_error_i,
   input  wire logic        store_address_error_i,
   input  wire logic        tlb_load_fault_i,
   input  wire logic        tlb_store_fault_i,
   input  wire logic        data_bus_error_i,
   input  wire logic        debug_load_compare_i,
   input  wire logic        complex_breakpoint_i,
   input  wire logic [2:0]  complex_kind_i,
   input  wire logic        exception_isa_select_i,
   input  wire logic [31:0] exception_base_i,
   input  wire logic        exl_clear_i,
   input  wire logic        erl_clear_i,
   output logic             take_o,
   output logic [31:0]      vector_o,
   output logic [4:0]       exception_code_o,
   output logic             code_valid_o,
   output logic             bootstrap_vector_bit_o,
   output logic             error_level_bit_o,
   output logic             soft_reset_flag_o,
   output logic             nmi_flag_o,
   output logic             exception_level_bit_o,
   output logic             machine_check_flag_o,
   output logic             watch_pending_o,
   output logic [2:0]       interrupt_priority_level_o,
   output logic [7:0]       debug_status_o,
   output logic             compressed_isa_o,
   output logic [4:0]       cause_code_o
);
   import exc_pkg::*;

   // ****************************************
   // State
   // ****************************************
   typedef struct packed {
      logic        take;
      logic [31:0] vector;
      logic [4:0]  code;
      logic        code_valid;
      logic        bootstrap_vector_bit;
      logic        error_level_bit;
      logic        srst;
      logic        nmi;
      logic        exception_level_bit;
      logic        mchk;
      logic        wp;
      logic [2:0]  ipl;
      logic [7:0]  dbg;
      logic        isa;
      logic [4:0]  cause;
      logic        por_seen;
   } state_s;

   state_s      st;
   state_s      next_st;
   logic [1:0]  rst_sync;
   logic        rstn;
   logic [26:0] pend;
   kind_e       kind;
   logic [4:0]  win_code;

   exc_sel_if sel ();

   // Reset release through two flops
   always_ff @(posedge clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
         rst_sync <= 2'b00;
      else
         rst_sync <= {rst_sync[0], 1'b1};
   end
   assign rstn = rst_sync[1];

   // ****************************************
   // Pending sources
   // ****************************************
   // Gather every source into its priority slot
   always_comb
   begin
      pend             = '0;
      pend[S_RESET]    = external_reset_pin_i | power_on_reset_i;
      pend[S_SOFT]     = soft_reset_req_i;
      pend[S_DSS]      = debug_single_step_i;
      pend[S_DEBUG_INTERRUPT]     = debug_interrupt_input_i | break_request_bit_i;
      pend[S_NMI]      = nmi_i;
      pend[S_MACHINE_CHECK_FLAG]   = tlb_conflict_i;
      pend[S_INT]      = int_req_i;
      pend[S_DWATCH]   = deferred_watch_i;
      pend[S_DIB]      = debug_instruction_break_i;
      pend[S_FWATCH]   = fetch_watch_i;
      pend[S_FADDR]    = fetch_address_error_i;
      pend[S_FTLB]     = tlb_fetch_fault_i;
      pend[S_XI]       = execute_inhibit_bit_i;
      pend[S_IBE]      = instruction_bus_error_i;
      pend[S_CPU]      = cop_unusable_i;
      pend[S_RI]       = reserved_instr_i;
      pend[S_EXEC]     = exec_fault_i;
      pend[S_TRAP]     = trap_exception_i;
      pend[S_DDB]      = debug_load_break_i | debug_store_break_i;
      pend[S_DWATCHD]  = data_watch_i;
      pend[S_LADDR]    = load_address_error_i;
      pend[S_SADDR]    = store_address_error_i;
      pend[S_LTLB]     = tlb_load_fault_i;
      pend[S_STLB]     = tlb_store_fault_i;
      pend[S_DBE]      = data_bus_error_i;
      pend[S_DEBUG_LOAD_BREAK_CMP] = debug_load_compare_i;
      pend[S_COMPLEX_BREAKPOINT]     = complex_breakpoint_i;
   end

   assign sel.pending = pend;

   exc_pick u_pick
   (
      .sel (sel)
   );

   // ****************************************
   // Classify the winner
   // ****************************************
   // Kind and code of the accepted source
   always_comb
   begin
      kind     = KIND_GENERAL;
      win_code = CODE_INT;
      case (int'(sel.index))
         S_RESET, S_SOFT, S_NMI: kind = KIND_RESET;
         S_DSS, S_DEBUG_INTERRUPT, S_DIB, S_DDB, S_DEBUG_LOAD_BREAK_CMP, S_COMPLEX_BREAKPOINT: kind = KIND_DEBUG;
         S_MACHINE_CHECK_FLAG: win_code = CODE_MACHINE_CHECK_FLAG;
         S_INT:
         begin
            kind     = KIND_INT;
            win_code = CODE_INT;
         end
         S_DWATCH, S_FWATCH, S_DWATCHD: win_code = CODE_WATCH;
         S_FADDR, S_LADDR: win_code = CODE_LOAD_FETCH_ADDRESS_ERROR;
         S_SADDR: win_code = CODE_STORE_ADDRESS_ERROR;
         S_FTLB, S_LTLB: win_code = CODE_TLB_LOAD_FETCH_FAULT;
         S_STLB: win_code = CODE_TLB_STORE_FAULT;
         S_XI: win_code = CODE_XI;
         S_IBE: win_code = CODE_IBE;
         S_DBE: win_code = CODE_DBE;
         S_CPU: win_code = CODE_CPU;
         S_RI: win_code = CODE_RI;
         S_EXEC:
         begin
            // Out of range codes fall back to the low end
            if (exec_code_i >= CODE_EXEC_LO && exec_code_i <= CODE_EXEC_HI)
               win_code = exec_code_i;
            else
               win_code = CODE_EXEC_LO;
         end
         S_TRAP: win_code = CODE_TRAP;
         default: win_code = CODE_INT;
      endcase
   end

   // ****************************************
   // Next state
   // ****************************************
   always_comb
   begin
      next_st            = st;
      next_st.take       = 1'b0;
      next_st.code_valid = 1'b0;
      next_st.por_seen   = 1'b1;
      next_st.isa        = exception_isa_select_i;
      // Software clear of EXL loses to a general exception, clear of ERL to a reset-class one
      if (exl_clear_i)
         next_st.exception_level_bit = 1'b0;
      if (erl_clear_i)
         next_st.error_level_bit = 1'b0;
      if (sel.any)
      begin
         next_st.take = 1'b1;
         case (kind)
            KIND_RESET:
            begin
               next_st.vector = RESET_VECTOR;
               next_st.bootstrap_vector_bit    = 1'b1;
               next_st.error_level_bit    = 1'b1;
               next_st.srst   = (int'(sel.index) == S_SOFT);
               next_st.nmi    = (int'(sel.index) == S_NMI);
            end
            KIND_DEBUG:
            begin
               next_st.vector = DEBUG_VECTOR;
               next_st.dbg    = '0;
               case (int'(sel.index))
                  S_DSS:  next_st.dbg[DB_DSS]  = 1'b1;
                  S_DEBUG_INTERRUPT: next_st.dbg[DB_DEBUG_INTERRUPT] = 1'b1;
                  S_DIB:  next_st.dbg[DB_DIB]  = 1'b1;
                  S_DDB:
                  begin
                     next_st.dbg[DB_DEBUG_LOAD_BREAK] = debug_load_break_i;
                     next_st.dbg[DB_DEBUG_STORE_BREAK] = debug_store_break_i;
                  end
                  S_DEBUG_LOAD_BREAK_CMP: next_st.dbg[DB_DEBUG_LOAD_BREAK] = 1'b1;
                  S_COMPLEX_BREAKPOINT:
                  begin
                     next_st.dbg[DB_IIMP] = complex_kind_i[0];
                     next_st.dbg[DB_LIMP] = complex_kind_i[1];
                     next_st.dbg[DB_SIMP] = complex_kind_i[2];
                  end
                  default: next_st.dbg = '0;
               endcase
            end
            KIND_INT:
            begin
               next_st.vector     = int_vector_i;
               next_st.ipl        = int_level_i;
               next_st.code       = win_code;
               next_st.code_valid = 1'b1;
               next_st.cause      = win_code;
            end
            default:
            begin
               // Fetch TLB fault at level zero uses the bare base
               if (int'(sel.index) == S_FTLB && !st.exception_level_bit)
                  next_st.vector = exception_base_i;
               else
                  next_st.vector = exception_base_i + GENERAL_OFS;
               next_st.exception_level_bit        = 1'b1;
               next_st.mchk       = (int'(sel.index) == S_MACHINE_CHECK_FLAG) | st.mchk;
               next_st.wp         = (int'(sel.index) == S_DWATCH);
               next_st.code       = win_code;
               next_st.code_valid = 1'b1;
               next_st.cause      = win_code;
            end
         endcase
      end
   end

   // State register
   always_ff @(posedge clk_i or negedge rstn)
   begin
      if (!rstn)
      begin
         st        <= '0;
         st.vector <= RESET_VECTOR;
         st.bootstrap_vector_bit    <= 1'b1;
         st.error_level_bit    <= 1'b1;
      end
      else
         st <= next_st;
   end

   // ****************************************
   // Outputs
   // ****************************************
   assign take_o                     = st.take;
   assign vector_o                   = st.vector;
   assign exception_code_o           = st.code;
   assign code_valid_o               = st.code_valid;
   assign bootstrap_vector_bit_o     = st.bootstrap_vector_bit;
   assign error_level_bit_o          = st.error_level_bit;
   assign soft_reset_flag_o          = st.srst;
   assign nmi_flag_o                 = st.nmi;
   assign exception_level_bit_o      = st.exception_level_bit;
   assign machine_check_flag_o       = st.mchk;
   assign watch_pending_o            = st.wp;
   assign interrupt_priority_level_o = st.ipl;
   assign debug_status_o             = st.dbg;
   assign compressed_isa_o           = st.isa;
   assign cause_code_o               = st.cause;

   // ****************************************
   // Checks
   // ****************************************
   property p_reset_vec;
      @(posedge clk_i) disable iff (!rstn)
      external_reset_pin_i |=> take_o && vector_o == 32'hbfc0_0000 && bootstrap_vector_bit_o
         && error_level_bit_o;
   endproperty
   a_reset_vec: assert property (p_reset_vec) else $error("reset vector wrong");

   property p_soft;
      @(posedge clk_i) disable iff (!rstn)
      soft_reset_req_i && !external_reset_pin_i && !power_on_reset_i |=> soft_reset_flag_o;
   endproperty
   a_soft: assert property (p_soft) else $error("soft reset flag missing");

   property p_nmi_rank;
      @(posedge clk_i) disable iff (!rstn)
      nmi_i && debug_single_step_i && !pend[S_RESET] && !soft_reset_req_i
         |=> debug_status_o[DB_DSS] && vector_o == 32'hbfc0_0480;
   endproperty
   a_nmi_rank: assert property (p_nmi_rank) else $error("nmi outranked step");

   property p_debug_interrupt;
      @(posedge clk_i) disable iff (!rstn)
      break_request_bit_i && pend[2:0] == 3'b000 |=> vector_o == 32'hbfc0_0480
         && debug_status_o[DB_DEBUG_INTERRUPT];
   endproperty
   a_debug_interrupt: assert property (p_debug_interrupt) else $error("debug interrupt missed");

   property p_machine_check_flag;
      @(posedge clk_i) disable iff (!rstn)
      sel.any && int'(sel.index) == S_MACHINE_CHECK_FLAG |=> exception_code_o == 5'h18
         && machine_check_flag_o && exception_level_bit_o;
   endproperty
   a_machine_check_flag: assert property (p_machine_check_flag) else $error("machine check wrong");

   property p_cpu_ri;
      @(posedge clk_i) disable iff (!rstn)
      sel.any && int'(sel.index) == S_CPU && reserved_instr_i |=> exception_code_o == 5'h0b;
   endproperty
   a_cpu_ri: assert property (p_cpu_ri) else $error("unusable not preferred");

   property p_ftlb;
      @(posedge clk_i) disable iff (!rstn)
      sel.any && int'(sel.index) == S_FTLB && !exception_level_bit_o
         |=> vector_o == $past(exception_base_i) && exception_code_o == 5'h02;
   endproperty
   a_ftlb: assert property (p_ftlb) else $error("fetch tlb vector wrong");

   property p_cause;
      @(posedge clk_i) disable iff (!rstn)
      code_valid_o |-> cause_code_o == exception_code_o;
   endproperty
   a_cause: assert property (p_cause) else $error("cause not recorded");

endmodule : cpu_exception_prioritizer

// >>> sim/exc_src_model.sv
`timescale 1ns/1ns
// ****************************************
// Pipeline side source model
// ****************************************
// Holds raised sources until taken; shows them on alternate cycles only
module exc_src_model
(
   input  wire logic        clk_i,
   input  wire logic        rstn_i,
   input  wire logic [26:0] add_i,
   output logic      [26:0] src_o
);
   logic [26:0] pend;
   logic        busy;
   logic [26:0] win;

   // Quiet cycle after each showing, so a source is not taken twice
   assign src_o = busy ? 27'h0 : pend;
   assign win   = src_o & (~src_o + 27'h1);

   // Raised sources join, the lowest index shown retires
   always_ff @(posedge clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         pend <= 27'h0;
         busy <= 1'b0;
      end
      else
      begin
         pend <= (pend & ~win) | add_i;
         busy <= |src_o;
      end
   end
endmodule : exc_src_model

// >>> sim/cpu_exception_prioritizer_bench.sv
`timescale 1ns/1ns
module cpu_exception_prioritizer_bench;
   import exc_pkg::*;
   typedef struct {int s; kind_e k; logic [4:0] c; logic [7:0] d;} row_s;
   localparam kind_e R = KIND_RESET, D = KIND_DEBUG, G = KIND_GENERAL, I = KIND_INT;
   localparam logic [31:0] BASE = 32'h9d00_1000;
   localparam logic [31:0] IVEC = 32'h9d00_0220;
   logic clk_i = 1'b0, rstn_i = 1'b0, power_on_reset_i = 1'b0, break_request_bit_i = 1'b0;
   logic debug_store_break_i = 1'b0, exception_isa_select_i = 1'b0;
   logic exl_clear_i = 1'b1, erl_clear_i = 1'b1;
   logic [2:0]  int_level_i = 3'h5, complex_kind_i = 3'h5;
   logic [4:0]  exec_code_i = 5'h09;
   logic [31:0] int_vector_i = IVEC, exception_base_i = BASE;
   logic [26:0] add = 27'h0, src;
   logic take_o, code_valid_o, bootstrap_vector_bit_o, error_level_bit_o, soft_reset_flag_o;
   logic nmi_flag_o, exception_level_bit_o, machine_check_flag_o, watch_pending_o;
   logic compressed_isa_o;
   logic [31:0] vector_o;
   logic [4:0]  exception_code_o, cause_code_o;
   logic [2:0]  interrupt_priority_level_o;
   logic [7:0]  debug_status_o;
   int n_mismatch = 0, n_tests = 0, cyc = 0, i;
   int order [8] = '{2, 3, 4, 9, 14, 15, 19, 26};
   // One row a source, in index order: kind, code, debug bits
   row_s rows [27] = '{
      '{0, R, 5'h00, 8'h00}, '{1, R, 5'h00, 8'h00}, '{2, D, 5'h00, 8'h01}, '{3, D, 5'h00, 8'h02},
      '{4, R, 5'h00, 8'h00}, '{5, G, 5'h18, 8'h00}, '{6, I, 5'h00, 8'h00}, '{7, G, 5'h17, 8'h00},
      '{8, D, 5'h00, 8'h04}, '{9, G, 5'h17, 8'h00}, '{10, G, 5'h04, 8'h00}, '{11, G, 5'h02, 8'h00},
      '{12, G, 5'h14, 8'h00}, '{13, G, 5'h06, 8'h00}, '{14, G, 5'h0b, 8'h00}, '{15, G, 5'h0a, 8'h00},
      '{16, G, 5'h09, 8'h00}, '{17, G, 5'h0d, 8'h00}, '{18, D, 5'h00, 8'h08}, '{19, G, 5'h17, 8'h00},
      '{20, G, 5'h04, 8'h00}, '{21, G, 5'h05, 8'h00}, '{22, G, 5'h02, 8'h00}, '{23, G, 5'h03, 8'h00},
      '{24, G, 5'h07, 8'h00}, '{25, D, 5'h00, 8'h08}, '{26, D, 5'h00, 8'ha0}};

   // ****************************************
   // Clock, partner and design
   // ****************************************
   always #25 clk_i = ~clk_i;

   exc_src_model u_exc_src_model (.clk_i(clk_i), .rstn_i(rstn_i), .add_i(add), .src_o(src));

   cpu_exception_prioritizer u_cpu_exception_prioritizer
   (
      .*,
      .external_reset_pin_i(src[0]), .soft_reset_req_i(src[1]), .debug_single_step_i(src[2]),
      .debug_interrupt_input_i(src[3]), .nmi_i(src[4]), .tlb_conflict_i(src[5]),
      .int_req_i(src[6]), .deferred_watch_i(src[7]), .debug_instruction_break_i(src[8]),
      .fetch_watch_i(src[9]), .fetch_address_error_i(src[10]), .tlb_fetch_fault_i(src[11]),
      .execute_inhibit_bit_i(src[12]), .instruction_bus_error_i(src[13]),
      .cop_unusable_i(src[14]), .reserved_instr_i(src[15]), .exec_fault_i(src[16]),
      .trap_exception_i(src[17]), .debug_load_break_i(src[18]), .data_watch_i(src[19]),
      .load_address_error_i(src[20]), .store_address_error_i(src[21]),
      .tlb_load_fault_i(src[22]), .tlb_store_fault_i(src[23]), .data_bus_error_i(src[24]),
      .debug_load_compare_i(src[25]), .complex_breakpoint_i(src[26])
   );

   // ****************************************
   // Helpers
   // ****************************************
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("[FAIL] %0t ns: got %h, expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic print_verdict();
      if (n_mismatch == 0 && n_tests > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : print_verdict

   // Bounded wait for the next take pulse
   task automatic wait_take();
      int n;
      n = 0;
      do
      begin
         @(negedge clk_i);
         n++;
      end
      while (take_o !== 1'b1 && n < 10);
   endtask : wait_take

   // Values held while reset is low
   task automatic check_reset();
      chk(vector_o, RESET_VECTOR);
      chk({take_o, code_valid_o, bootstrap_vector_bit_o, error_level_bit_o, exception_level_bit_o,
           soft_reset_flag_o, nmi_flag_o, machine_check_flag_o, watch_pending_o}, 9'h060);
      chk({debug_status_o, interrupt_priority_level_o, cause_code_o}, 16'h0000);
   endtask : check_reset

   // Results of one take against its row
   task automatic check_row(input row_s r);
      logic [31:0] ev;
      ev = (r.s == S_FTLB) ? BASE : BASE + GENERAL_OFS;
      if (r.k == R) ev = RESET_VECTOR;
      if (r.k == D) ev = DEBUG_VECTOR;
      if (r.k == I) ev = IVEC;
      chk(take_o, 1'b1);
      chk(vector_o, ev);
      chk(code_valid_o, r.k inside {G, I});
      chk(compressed_isa_o, exception_isa_select_i);
      if (r.k == R) chk({bootstrap_vector_bit_o, error_level_bit_o, soft_reset_flag_o,
                         nmi_flag_o}, {2'b11, r.s == S_SOFT, r.s == S_NMI});
      if (r.k == D) chk(debug_status_o, r.d);
      if (r.k inside {G, I})
         chk({exception_code_o, cause_code_o}, {r.c, r.c});
      if (r.k == G) chk({watch_pending_o, exception_level_bit_o | (r.s == S_FTLB)},
                        {r.s == S_DWATCH, 1'b1});
      if (r.k == I) chk(interrupt_priority_level_o, 3'h5);
      if (r.s >= S_MACHINE_CHECK_FLAG) chk(machine_check_flag_o, 1'b1);
      @(negedge clk_i);
      chk(take_o, 1'b0);
   endtask : check_row

   // Ceiling on run length
   always @(posedge clk_i)
   begin
      cyc++;
      if (cyc == 5000)
      begin
         n_mismatch++;
         print_verdict();
      end
   end

   // ****************************************
   // Main sequence
   // ****************************************
   initial
   begin
      repeat (6) @(negedge clk_i);
      check_reset();
      rstn_i = 1'b1;
      repeat (4) @(negedge clk_i);
      // Each source alone
      for (i = 0; i < 27; i++)
      begin
         exception_isa_select_i = i[0];
         add = 27'h1 << rows[i].s;
         @(negedge clk_i);
         add = 27'h0;
         wait_take();
         check_row(rows[i]);
      end
      // Many pending at once, taken in fixed order
      exception_isa_select_i = 1'b0;
      add = 27'h408_c21c;
      @(negedge clk_i);
      add = 27'h0;
      foreach (order[k])
      begin
         wait_take();
         check_row(rows[order[k]]);
      end
      // Fetch TLB fault with exception level already set
      exl_clear_i = 1'b0;
      add = 27'h1 << S_CPU;
      @(negedge clk_i);
      add = 27'h1 << S_FTLB;
      wait_take();
      check_row(rows[S_CPU]);
      add = 27'h0;
      wait_take();
      chk({vector_o, exception_code_o}, {BASE + GENERAL_OFS, 5'h02});
      exl_clear_i = 1'b1;
      @(negedge clk_i);
      chk({exception_level_bit_o, error_level_bit_o}, 2'b00);
      // Break request bit, then store break
      break_request_bit_i = 1'b1;
      wait_take();
      chk({vector_o, debug_status_o}, {DEBUG_VECTOR, 8'h02});
      break_request_bit_i = 1'b0;
      debug_store_break_i = 1'b1;
      wait_take();
      chk({vector_o, debug_status_o}, {DEBUG_VECTOR, 8'h10});
      debug_store_break_i = 1'b0;
      repeat (2) @(negedge clk_i);
      // Second reset mid-run, then power-on reset source
      rstn_i = 1'b0;
      @(negedge clk_i);
      check_reset();
      rstn_i = 1'b1;
      repeat (4) @(negedge clk_i);
      power_on_reset_i = 1'b1;
      wait_take();
      chk({vector_o, bootstrap_vector_bit_o, error_level_bit_o}, {RESET_VECTOR, 2'b11});
      power_on_reset_i = 1'b0;
      print_verdict();
   end
endmodule : cpu_exception_prioritizer_bench
